/* hw/ebls_lane_steer.sv */
// Lane steering and access splitting between the 32-bit internal path
// and an 8/16/32-bit external memory bus.
// Assumes the bank decoder supplies the bank index and the bank control
// registers supply each bank's width field; the memory side answers every
// transfer with ext_done_i (read data valid on that cycle).
//
// Operation
// (RULE_01) 32-bit bus word: one transfer, data unchanged, all lanes on.
// (RULE_02) Big-endian 16-bit word: bits 31:16 at WA, then 15:0 at WA+2.
// (RULE_03) Big-endian 8-bit word: four bytes WA..WA+3, MSB first.
// (RULE_04) Little-endian 16-bit word: bits 15:0 at WA, then 31:16.
// (RULE_05) Little-endian 8-bit word: four bytes, LSB first, assembled upward.
// (RULE_06) Word address aligned; split steps add the bus width in bytes.
// (RULE_07) Big-endian 32-bit half write: replicate, A1=0 upper lanes.
// (RULE_08) Big-endian 32-bit half read: A1=0 returns bits 31:16.
// (RULE_09) Little-endian 32-bit half write: replicate, A1=0 lower lanes.
// (RULE_10) Little-endian 32-bit half read: A1=0 returns bits 15:0.
// (RULE_11) 16-bit bus half: one transfer on bits 15:0, low two lanes.
// (RULE_12) 8-bit bus half: two bytes HA, HA+1; order by endianness.
// (RULE_13) Big-endian 32-bit byte write: replicate, offset 0 is bits 31:24.
// (RULE_14) Big-endian 32-bit byte read: same lane mapping, result in 7:0.
// (RULE_15) Little-endian 32-bit byte: offset 0 is bits 7:0.
// (RULE_16) 16-bit bus byte: even address; lane by offset and endianness.
// (RULE_17) 8-bit bus byte: one transfer at exact address, lowest lane.
// (RULE_18) Lane enables driven per lane; strobes for writes, mask always.
// (RULE_19) Bus width taken from the addressed bank's width field.
// (RULE_20) Endian strap high at power-on selects little-endian.
// (RULE_21) Address pins take A21:0, A22:1 or A23:2 by width.
// (RULE_22) Request held until every split transfer finishes.
`default_nettype none
module ebls_lane_steer
  import ebls_pkg::*;
#(
  parameter int NUM_BANKS = 8
) (
  input  wire logic                 core_clk_i,
  input  wire logic                 reset_n_i,
  input  wire logic                 endian_strap_pin_i,
  input  wire logic [NUM_BANKS*2-1:0] bank_bus_width_field_i,
  input  wire logic                 req_valid_i,
  input  wire ebls_req_t            req_i,
  output logic                      req_ready_o,
  output logic                      rsp_valid_o,
  output logic [31:0]               rsp_data_o,
  output logic                      ext_valid_o,
  output ebls_xfer_t                ext_o,
  input  wire logic                 ext_done_i,
  input  wire logic [31:0]          ext_rdata_i,
  output logic                      little_endian_o
);

  // ----------------------------------------------------------------
  // Strap capture
  // ----------------------------------------------------------------
  logic strap_taken;

  // Catch the strap on the first clock after reset release
  always_ff @(posedge core_clk_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      strap_taken     <= 1'b0;
      little_endian_o <= 1'b0;
    end else if (!strap_taken) begin
      strap_taken     <= 1'b1;
      little_endian_o <= endian_strap_pin_i; // see RULE_20
    end
  end

  // ----------------------------------------------------------------
  // Request capture and sequencing
  // ----------------------------------------------------------------
  ebls_state_t state;
  ebls_req_t   req;
  logic [1:0]  width;
  logic [1:0]  xfer_idx;
  logic [1:0]  xfer_last;
  logic [31:0] rd_acc;
  logic [1:0]  next_width;
  logic [1:0]  bank_idx;

  assign bank_idx    = req_i.bank;
  assign next_width  = bank_bus_width_field_i[bank_idx*2 +: 2]; // see RULE_19
  assign req_ready_o = (state == EBLS_IDLE) && strap_taken;

  // Number of transfers minus one for the captured access
  always_comb begin
    xfer_last = EBLS_XFER_ZERO;
    if (width == EBLS_WIDTH_16 && req.size == EBLS_SIZE_WORD) begin
      xfer_last = 2'h1; // see RULE_02
    end else if (width == EBLS_WIDTH_8) begin
      if (req.size == EBLS_SIZE_WORD) begin
        xfer_last = 2'h3; // see RULE_03
      end else if (req.size == EBLS_SIZE_HALF) begin
        xfer_last = 2'h1; // see RULE_12
      end
    end
  end

  // Main sequencer: hold the request until all transfers finish
  always_ff @(posedge core_clk_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      state    <= EBLS_IDLE;
      req      <= '0;
      width    <= EBLS_WIDTH_8;
      xfer_idx <= EBLS_XFER_ZERO;
    end else begin
      case (state)
        EBLS_IDLE: begin
          if (req_valid_i && req_ready_o) begin
            req      <= req_i;
            width    <= next_width;
            xfer_idx <= EBLS_XFER_ZERO;
            state    <= EBLS_XFER;
          end
        end
        EBLS_XFER: begin
          if (ext_done_i) begin
            if (xfer_idx == xfer_last) begin
              state <= EBLS_DONE; // see RULE_22
            end else begin
              xfer_idx <= xfer_idx + 2'h1;
            end
          end
        end
        EBLS_DONE: begin
          state <= EBLS_IDLE;
        end
        default: begin
          state <= EBLS_IDLE;
        end
      endcase
    end
  end

  // ----------------------------------------------------------------
  // Transfer generation
  // ----------------------------------------------------------------
  logic [23:0] byte_addr;
  logic [1:0]  lane;
  logic [3:0]  lanes_n;
  logic [31:0] wdata;
  logic [1:0]  chunk;
  logic        le;

  assign le = little_endian_o;

  // Address, lanes and write data of the current transfer
  always_comb begin
    byte_addr = req.system_address[23:0];
    lane      = req.system_address[1:0];
    lanes_n   = EBLS_LANES_OFF;
    wdata     = req.internal_bus_data;
    chunk     = xfer_idx;
    case (width)
      EBLS_WIDTH_32: begin
        byte_addr[1:0] = 2'h0; // see RULE_06
        if (req.size == EBLS_SIZE_WORD) begin
          lanes_n = EBLS_LANES_ALL; // see RULE_01
        end else if (req.size == EBLS_SIZE_HALF) begin
          wdata = {2{req.internal_bus_data[15:0]}}; // see RULE_07
          // Big-endian A1=0 upper pair; little-endian reversed
          if (req.system_address[1] ^ le) begin
            lanes_n = EBLS_LANES_LOW2; // see RULE_09
          end else begin
            lanes_n = EBLS_LANES_HIGH2; // see RULE_07
          end
        end else begin
          wdata = {4{req.internal_bus_data[7:0]}}; // see RULE_13
          lane  = le ? req.system_address[1:0]
                     : ~req.system_address[1:0]; // see RULE_15
          lanes_n        = EBLS_LANES_OFF;
          lanes_n[lane]  = EBLS_LANE_ON; // see RULE_14
        end
      end
      EBLS_WIDTH_16: begin
        lanes_n = EBLS_LANES_LOW2; // see RULE_11
        if (req.size == EBLS_SIZE_WORD) begin
          byte_addr[1:0] = {xfer_idx[0], 1'b0}; // see RULE_06
          chunk = {1'b0, xfer_idx[0] ^ ~le};
          wdata = {16'h0000, chunk[0] ? req.internal_bus_data[31:16]
                                      : req.internal_bus_data[15:0]};
        end else if (req.size == EBLS_SIZE_HALF) begin
          byte_addr[0] = 1'b0;
          wdata = {16'h0000, req.internal_bus_data[15:0]}; // see RULE_11
        end else begin
          byte_addr[0] = 1'b0; // see RULE_16
          wdata = {16'h0000, {2{req.internal_bus_data[7:0]}}};
          lanes_n = EBLS_LANES_OFF;
          lanes_n[{1'b0, req.system_address[0] ^ ~le}] = EBLS_LANE_ON;
        end
      end
      default: begin
        lanes_n = EBLS_LANE0_ONLY; // see RULE_17
        if (req.size == EBLS_SIZE_WORD) begin
          byte_addr[1:0] = xfer_idx; // see RULE_03
          chunk = le ? xfer_idx : ~xfer_idx; // see RULE_05
        end else if (req.size == EBLS_SIZE_HALF) begin
          byte_addr[0] = xfer_idx[0]; // see RULE_12
          chunk = {1'b0, le ? xfer_idx[0] : ~xfer_idx[0]};
        end else begin
          chunk = EBLS_XFER_ZERO; // see RULE_17
        end
        wdata = {24'h000000, req.internal_bus_data[chunk*8 +: 8]};
      end
    endcase
  end

  // Registered transfer outputs
  always_ff @(posedge core_clk_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      ext_valid_o <= 1'b0;
      ext_o       <= '{external_address: 22'h000000,
                       external_data: 32'h00000000,
                       byte_write_strobes_n: EBLS_LANES_OFF,
                       sdram_lane_mask_n: EBLS_LANES_OFF,
                       write: 1'b0};
    end else if (state == EBLS_XFER && !(ext_done_i && ext_valid_o)) begin
      ext_valid_o <= 1'b1;
      // Address pins take the slice set by the bus width
      case (width)
        EBLS_WIDTH_32: ext_o.external_address <= byte_addr[23:2];
        EBLS_WIDTH_16: ext_o.external_address <= byte_addr[22:1];
        default:       ext_o.external_address <= byte_addr[21:0];
      endcase // see RULE_21
      ext_o.external_data        <= wdata;
      ext_o.sdram_lane_mask_n    <= lanes_n; // see RULE_18
      ext_o.byte_write_strobes_n <= req.write ? lanes_n : EBLS_LANES_OFF;
      ext_o.write                <= req.write;
    end else begin
      ext_valid_o                <= 1'b0;
      ext_o.byte_write_strobes_n <= EBLS_LANES_OFF;
      ext_o.sdram_lane_mask_n    <= EBLS_LANES_OFF;
    end
  end

  // ----------------------------------------------------------------
  // Read assembly
  // ----------------------------------------------------------------
  logic [31:0] next_rd_acc;

  // Merge the returned lanes into the read word
  always_comb begin
    next_rd_acc = rd_acc;
    case (width)
      EBLS_WIDTH_32: begin
        if (req.size == EBLS_SIZE_WORD) begin
          next_rd_acc = ext_rdata_i; // see RULE_01
        end else if (req.size == EBLS_SIZE_HALF) begin
          next_rd_acc = {16'h0000, (req.system_address[1] ^ le) // see RULE_10
                         ? ext_rdata_i[15:0]
                         : ext_rdata_i[31:16]}; // see RULE_08
        end else begin
          next_rd_acc = {24'h000000, ext_rdata_i[lane*8 +: 8]}; // see RULE_14
        end
      end
      EBLS_WIDTH_16: begin
        if (req.size == EBLS_SIZE_WORD) begin
          next_rd_acc[chunk[0]*16 +: 16] = ext_rdata_i[15:0]; // see RULE_04
        end else if (req.size == EBLS_SIZE_HALF) begin
          next_rd_acc = {16'h0000, ext_rdata_i[15:0]};
        end else begin
          next_rd_acc = {24'h000000, (req.system_address[0] ^ ~le)
                         ? ext_rdata_i[15:8] : ext_rdata_i[7:0]};
        end
      end
      default: begin
        if (req.size == EBLS_SIZE_BYTE) begin
          next_rd_acc = {24'h000000, ext_rdata_i[7:0]};
        end else begin
          next_rd_acc[chunk*8 +: 8] = ext_rdata_i[7:0]; // see RULE_05
        end
      end
    endcase
  end

  // Accumulate read data; clear at each new request
  always_ff @(posedge core_clk_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      rd_acc <= 32'h00000000;
    end else if (state == EBLS_IDLE) begin
      rd_acc <= 32'h00000000;
    end else if (state == EBLS_XFER && ext_done_i) begin
      rd_acc <= next_rd_acc;
    end
  end

  // Completion answer only after the last transfer
  always_ff @(posedge core_clk_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      rsp_valid_o <= 1'b0;
      rsp_data_o  <= 32'h00000000;
    end else begin
      rsp_valid_o <= (state == EBLS_XFER) && ext_done_i
                     && (xfer_idx == xfer_last); // see RULE_22
      if (state == EBLS_XFER && ext_done_i && !req.write) begin
        rsp_data_o <= next_rd_acc;
      end
    end
  end

endmodule : ebls_lane_steer
`default_nettype wire

/* hw/ebls_pkg.sv */
// Package for the external bus lane steering block.
// Assumes one system clock domain; no software-visible registers.
`default_nettype none
package ebls_pkg;
  // Bus width field encodings (per-bank width selector)
  localparam logic [1:0] EBLS_WIDTH_8  = 2'h0;
  localparam logic [1:0] EBLS_WIDTH_16 = 2'h1;
  localparam logic [1:0] EBLS_WIDTH_32 = 2'h2;
  // Access size encodings
  localparam logic [1:0] EBLS_SIZE_BYTE = 2'h0;
  localparam logic [1:0] EBLS_SIZE_HALF = 2'h1;
  localparam logic [1:0] EBLS_SIZE_WORD = 2'h2;
  // Lane enable levels and reset values
  localparam logic       EBLS_LANE_ON     = 1'b0;
  localparam logic [3:0] EBLS_LANES_OFF   = 4'hf;
  localparam logic [3:0] EBLS_LANES_ALL   = 4'h0;
  localparam logic [3:0] EBLS_LANE0_ONLY  = 4'he;
  localparam logic [3:0] EBLS_LANES_LOW2  = 4'hc;
  localparam logic [3:0] EBLS_LANES_HIGH2 = 4'h3;
  localparam logic [1:0] EBLS_XFER_ZERO   = 2'h0;
  // Processor request
  typedef struct packed {
    logic [31:0] system_address;
    logic [31:0] internal_bus_data;
    logic [1:0]  size;
    logic        write;
    logic [1:0]  bank;
  } ebls_req_t;
  // One external transfer
  typedef struct packed {
    logic [21:0] external_address;
    logic [31:0] external_data;
    logic [3:0]  byte_write_strobes_n;
    logic [3:0]  sdram_lane_mask_n;
    logic        write;
  } ebls_xfer_t;
  typedef enum logic [2:0] {
    EBLS_IDLE = 3'b001,
    EBLS_XFER = 3'b010,
    EBLS_DONE = 3'b100
  } ebls_state_t;
endpackage : ebls_pkg
`default_nettype wire

/* sim/ebls_mem_model.sv */
// Memory on the far side: answers each transfer promptly or slowly.
// Assumes the block holds a transfer until it sees the answer.
`default_nettype none
module ebls_mem_model
  import ebls_pkg::*;
(
  input  wire logic       core_clk_i,
  input  wire logic       reset_n_i,
  input  wire logic       ext_valid_i,
  input  wire ebls_xfer_t xfer_i,
  input  wire logic       slow_i,
  output logic            done_o,
  output logic [31:0]     rdata_o
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [1:0]  wait_cnt;
  logic [31:0] last;
  logic [7:0]  a;
  // ----
  // Answer after zero or three wait cycles
  // ----
  assign a = xfer_i.external_address[7:0];
  assign done_o = ext_valid_i && wait_cnt == (slow_i ? 2'h3 : 2'h0);
  // Lanes differ per address; off the answer the bus shows stale inverse
  assign rdata_o = done_o ? {a ^ 8'h5a, a ^ 8'h3c, a, ~a} : ~last;
  // Count wait cycles of the current transfer
  always_ff @(posedge core_clk_i or negedge reset_n_i) begin
    if (!reset_n_i) wait_cnt <= 2'h0;
    else wait_cnt <= (ext_valid_i && !done_o) ? wait_cnt + 2'h1 : 2'h0;
  end
  // Remember the last value driven
  always_ff @(posedge core_clk_i or negedge reset_n_i) begin
    if (!reset_n_i) last <= 32'h0;
    else if (done_o) last <= rdata_o;
  end
endmodule : ebls_mem_model
`default_nettype wire

/* sim/ebls_sva.sv */
// Concurrent checks on the lane steering block's handshake and lanes.
// Assumes it is bound to the block and sees only its ports.
`default_nettype none
module ebls_sva
  import ebls_pkg::*;
(
  input wire logic       core_clk_i,
  input wire logic       reset_n_i,
  input wire logic       req_valid_i,
  input wire logic       req_ready_o,
  input wire logic       rsp_valid_o,
  input wire logic       ext_valid_o,
  input wire ebls_xfer_t ext_o,
  input wire logic       ext_done_i
);
  timeunit 1ns;
  timeprecision 1ps;
  default clocking @(posedge core_clk_i); endclocking
  default disable iff (!reset_n_i);
  // ----
  // Transfer and response handshake, idle lanes and write strobes
  // ----
  xfer_hold_a: assert property (
    ext_valid_o && !ext_done_i |=> ext_valid_o && $stable(ext_o))
    else $error("transfer changed before its answer");
  xfer_drop_a: assert property (
    ext_valid_o && ext_done_i |=> !ext_valid_o)
    else $error("transfer not dropped after answer");
  idle_lanes_a: assert property (
    !ext_valid_o |-> ext_o.sdram_lane_mask_n == 4'hf &&
      ext_o.byte_write_strobes_n == 4'hf)
    else $error("lanes active with no transfer");
  read_strobe_a: assert property (
    ext_valid_o && !ext_o.write |-> ext_o.byte_write_strobes_n == 4'hf)
    else $error("write strobe on a read");
  write_strobe_a: assert property (
    ext_valid_o && ext_o.write |->
      ext_o.byte_write_strobes_n == ext_o.sdram_lane_mask_n)
    else $error("write strobes differ from lane mask");
  first_xfer_a: assert property (
    req_valid_i && req_ready_o |=> !req_ready_o ##[1:2] ext_valid_o)
    else $error("no transfer after a taken request");
  rsp_cause_a: assert property (
    rsp_valid_o |-> $past(ext_done_i) && !ext_valid_o)
    else $error("response without a finished transfer");
  rsp_pulse_a: assert property (
    rsp_valid_o |-> !req_ready_o ##1 !rsp_valid_o && req_ready_o)
    else $error("response not a single pulse before idle");
endmodule : ebls_sva
`default_nettype wire

/* sim/tb_top.sv */
// Bench for the lane steering block: row table, then hand cases.
// Assumes the memory model answers every transfer it is shown.
`default_nettype none
module tb_top import ebls_pkg::*; ;
  timeunit 1ns;
  timeprecision 1ps;
  typedef struct packed {
    logic [3:0]  le, w, sz, wr, n, m;
    logic [15:0] a;
  } ebls_row_t;
  logic        core_clk_i, reset_n_i, endian_strap_pin_i, mem_slow;
  logic        req_valid_i, req_ready_o, rsp_valid_o, ext_valid_o;
  logic        ext_done_i, little_endian_o;
  logic [15:0] bank_bus_width_field_i;
  logic [31:0] rsp_data_o, ext_rdata_i, qd[$];
  ebls_req_t   req_i;
  ebls_xfer_t  ext_o, qx[$];
  int          n_mismatch = 0;
  int          checked = 0;
  // Endian, width, size, write, beats, first mask, then address
  ebls_row_t rows[19] = '{
    40'h022110_0104, 40'h01212c_0208, 40'h00204e_030c,
    40'h021113_0400, 40'h02101c_0402, 40'h01101c_0506,
    40'h00112e_060a, 40'h020117_0700, 40'h02001d_0702,
    40'h01001e_0801, 40'h00011e_0903, 40'h122010_0a04,
    40'h11202c_0b00, 40'h10214e_0c08, 40'h121113_0d02,
    40'h12101c_0d00, 40'h10102e_0e02, 40'h120017_0f03,
    40'h11011e_1000};
  ebls_lane_steer #(.NUM_BANKS(8)) DUT (.core_clk_i, .reset_n_i,
    .endian_strap_pin_i, .bank_bus_width_field_i, .req_valid_i, .req_i,
    .req_ready_o, .rsp_valid_o, .rsp_data_o, .ext_valid_o, .ext_o,
    .ext_done_i, .ext_rdata_i, .little_endian_o);
  ebls_mem_model u_mem (.core_clk_i, .reset_n_i, .ext_valid_i(ext_valid_o),
    .xfer_i(ext_o), .slow_i(mem_slow), .done_o(ext_done_i),
    .rdata_o(ext_rdata_i));
  // ----
  // Clock, transfer log and hang guard
  // ----
  initial begin
    core_clk_i = 1'b0;
    forever #2 core_clk_i = ~core_clk_i;
  end
  always @(posedge core_clk_i) begin
    if (ext_valid_o && ext_done_i) begin
      qx.push_back(ext_o);
      qd.push_back(ext_rdata_i);
    end
  end
  initial begin
    #200000;
    n_mismatch++;
    summarize();
  end
  // ----
  // Tasks
  // ----
  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    checked++;
    if (seen !== exp) begin
      n_mismatch++;
      $display("[FAIL] t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask : chk
  task automatic rst(input logic le);
    @(negedge core_clk_i);
    reset_n_i = 1'b0;
    endian_strap_pin_i = le;
    req_valid_i = 1'b0;
    repeat (20) @(negedge core_clk_i);
    chk(32'({ext_valid_o, rsp_valid_o, req_ready_o}), 32'h0);
    chk(32'(ext_o.sdram_lane_mask_n), 32'hf);
    chk(32'(ext_o.byte_write_strobes_n), 32'hf);
    chk(rsp_data_o, 32'h0);
    reset_n_i = 1'b1;
    repeat (2) @(negedge core_clk_i);
    chk(32'(little_endian_o), 32'(le));
    // Strap is taken once; a later change must not reach the mode
    endian_strap_pin_i = ~le;
    @(negedge core_clk_i);
    chk(32'(little_endian_o), 32'(le));
    endian_strap_pin_i = le;
    qx.delete();
    qd.delete();
  endtask : rst
  task automatic run(input ebls_row_t r, input logic [31:0] d,
                     input logic s);
    int sb, bw, base, ba, m, l, v;
    logic [31:0] ed, dm, rb;
    logic [3:0] em;
    sb = 1 << r.sz;
    bw = 1 << r.w;
    base = int'(r.a) & ~((sb > bw ? sb : bw) - 1);
    rb = 32'h0;
    @(negedge core_clk_i);
    mem_slow = s;
    bank_bus_width_field_i = {8{~r.w[1:0]}};
    bank_bus_width_field_i[2 * int'(r.a[9:8]) +: 2] = r.w[1:0];
    req_i = '{32'(r.a), d, r.sz[1:0], r.wr[0], r.a[9:8]};
    req_valid_i = 1'b1;
    for (int t = 0; t < 50 && req_ready_o !== 1'b1; t++) @(negedge core_clk_i);
    @(negedge core_clk_i);
    req_valid_i = 1'b0;
    for (int t = 0; t < 200 && rsp_valid_o !== 1'b1; t++)
      @(negedge core_clk_i);
    chk(32'(qx.size()), 32'(r.n));
    if (qx.size() > 0)
      chk(32'(qx[0].sdram_lane_mask_n), 32'(r.m));
    foreach (qx[k]) begin
      ba = base + k * bw;
      em = 4'hf;
      ed = 32'h0;
      dm = 32'h0;
      for (int j = 0; j < bw; j++) begin
        m = ba + j - (int'(r.a) & ~(sb - 1));
        l = r.le[0] ? j : bw - 1 - j;
        v = r.le[0] ? m : sb - 1 - m;
        if (m >= 0 && m < sb) begin
          em[l] = 1'b0;
          ed[8 * l +: 8] = d[8 * v +: 8];
          dm[8 * l +: 8] = 8'hff;
          rb[8 * v +: 8] = qd[k][8 * l +: 8];
        end
      end
      chk(32'(qx[k].external_address), 32'(ba >> r.w));
      chk(32'(qx[k].sdram_lane_mask_n), 32'(em));
      chk(32'(qx[k].byte_write_strobes_n),
          r.wr[0] ? 32'(em) : 32'hf);
      chk(32'(qx[k].write), 32'(r.wr[0]));
      if (r.wr[0]) chk(qx[k].external_data & dm, ed);
    end
    if (!r.wr[0])
      chk(rsp_data_o & (32'hffffffff >> (32 - 8 * sb)), rb);
    qx.delete();
    qd.delete();
  endtask : run
  task automatic summarize();
    if (n_mismatch == 0 && checked > 0) $display("Regression OK");
    else $display("Regression broken");
    $finish;
  endtask : summarize
  // ----
  // Main sequence
  // ----
  initial begin
    reset_n_i = 1'b0;
    endian_strap_pin_i = 1'b0;
    mem_slow = 1'b0;
    req_valid_i = 1'b0;
    req_i = '0;
    bank_bus_width_field_i = 16'h0;
    rst(1'b0);
    foreach (rows[i]) begin
      if (rows[i].le[0] !== little_endian_o) rst(rows[i].le[0]);
      run(rows[i], 32'h4d3c2b1a + 32'(i), i[0]);
    end
    // Reset while a slow split write is still in flight
    @(negedge core_clk_i);
    mem_slow = 1'b1;
    bank_bus_width_field_i = 16'h0;
    req_i = '{32'h0c08, 32'h0, 2'h2, 1'b1, 2'h0};
    req_valid_i = 1'b1;
    repeat (2) @(negedge core_clk_i);
    req_valid_i = 1'b0;
    repeat (6) @(negedge core_clk_i);
    // Second byte is on the bus, first one done, no answer yet
    chk(32'({ext_valid_o, rsp_valid_o}), 32'h2);
    chk(32'(qx.size()), 32'h1);
    rst(1'b0);
    run(rows[0], 32'h1, 1'b0);
    summarize();
  end
endmodule : tb_top
bind ebls_lane_steer ebls_sva u_sva (.core_clk_i, .reset_n_i, .req_valid_i,
  .req_ready_o, .rsp_valid_o, .ext_valid_o, .ext_o, .ext_done_i);
`default_nettype wire
